/* design/eeprom_target.sv */
// Purpose: Bus-target protocol logic of a two-wire serial EEPROM.
// Assumes: Link pins are sampled by the system clock through synchronisers.
// Notes:   Storage is flip-flops; the lock bit clears only on I_RESET.
//
// Design decisions made here: two-stage pin synchronisers and page writes staged until the program time ends.
`timescale 1ns/10ps
`include "eeprom_defines.svh"
module eeprom_target #(
	parameter int unsigned PROGRAM_CYCLES = `PROGRAM_TIME_US * `CLK_MHZ
) (
	input  wire logic      I_CLK,
	input  wire logic      I_RESET,
	input  wire logic      I_SELECT_PIN_2,
	input  wire logic      I_SELECT_PIN_1,
	input  wire logic      I_SELECT_PIN_0,
	input  wire logic      I_WRITE_PROTECT,
	output logic           O_BUSY,
	output logic           O_ID_LOCKED,
	eeprom_link_if.target  LINK
);

	////////////////////////////////////////////////////////////////////////
	logic [5:0]                 sync1;
	logic [5:0]                 sync2;
	logic                       scl_q;
	logic                       sda_q;
	logic                       scl_s;
	logic                       sda_s;
	logic                       protect;
	logic [2:0]                 select;
	logic                       scl_rise;
	logic                       scl_fall;
	logic                       start_seen;
	logic                       stop_seen;
	eeprom_pkg::dev_state_t     state;
	eeprom_pkg::phase_t         phase;
	eeprom_pkg::kind_t          kind;
	logic                       rd;
	logic [3:0]                 bit_cnt;
	logic [7:0]                 shreg;
	logic [7:0]                 addr_hi;
	logic [`ADDR_W-1:0]         counter;
	logic                       drive_low;
	logic                       ack_q;
	logic                       master_ack;
	logic                       wr_armed;
	logic                       lock;
	logic                       pend_lock;
	logic [19:0]                prog_cnt;
	logic [`PAGE_BYTES-1:0]     buf_valid;
	logic [7:0]                 buf_data [`PAGE_BYTES];
	logic [7:0]                 mem      [`ARRAY_BYTES];
	logic [7:0]                 id_mem   [`PAGE_BYTES];
	logic                       next_ack;
	logic [7:0]                 tx_byte;
	logic                       commit;

	// Address step: full wrap across the array, or wrap within one page.
	function automatic logic [`ADDR_W-1:0] bump(input logic [`ADDR_W-1:0] a,
		input logic full);
		logic [`OFS_W-1:0] ofs;
		ofs = a[`OFS_W-1:0] + 5'h01;
		bump = full ? a + 13'h0001 : {a[`ADDR_W-1:`OFS_W], ofs};
	endfunction : bump

	////////////////////////////////////////////////////////////////////////
	// Two flip-flops on every pin before any logic reads it.
	always_ff @(posedge I_CLK) begin
		sync1 <= {LINK.scl, LINK.sda_level, I_WRITE_PROTECT, I_SELECT_PIN_2,
			I_SELECT_PIN_1, I_SELECT_PIN_0};
		sync2 <= sync1;
		scl_q <= sync2[5];
		sda_q <= sync2[4];
	end

	// Edges and bus conditions compare the second stage with the third (scl_q, sda_q).
	assign scl_s      = sync2[5];
	assign sda_s      = sync2[4];
	assign protect    = sync2[3];
	assign select     = sync2[2:0];
	assign scl_rise   = scl_s & ~scl_q;
	assign scl_fall   = ~scl_s & scl_q;
	assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;

	////////////////////////////////////////////////////////////////////////
	// Answer to the byte just received, decided by phase and command kind.
	always_comb begin
		next_ack = 1'b0;
		case (phase)
			eeprom_pkg::ph_dev: begin
				next_ack = (shreg[7:4] == `TYPE_ARRAY ||
					shreg[7:4] == `TYPE_IDPAGE) && shreg[3:1] == select;
			end
			eeprom_pkg::ph_ahi, eeprom_pkg::ph_alo: begin
				next_ack = 1'b1;
			end
			eeprom_pkg::ph_data: begin
				case (kind)
					eeprom_pkg::k_array: next_ack = ~protect;
					eeprom_pkg::k_idpage: next_ack = ~protect & ~lock;
					eeprom_pkg::k_lock: begin
						next_ack = ~protect & ~lock & shreg[`LOCK_DATA_BIT];
					end
					default: next_ack = 1'b0;
				endcase
			end
			default: next_ack = 1'b0;
		endcase
	end

	// Read data follows the shared counter into the selected store.
	assign tx_byte = (kind == eeprom_pkg::k_array) ? mem[counter] :
		id_mem[counter[`OFS_W-1:0]];
	assign commit  = (state == eeprom_pkg::st_prog) && (prog_cnt == 20'h00000);

	////////////////////////////////////////////////////////////////////////
	// Protocol engine. While programming every bus input is ignored, so a
	// polling address byte simply sees no acknowledge.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			state      <= eeprom_pkg::st_idle;
			phase      <= eeprom_pkg::ph_dev;
			kind       <= eeprom_pkg::k_array;
			rd         <= 1'b0;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			addr_hi    <= 8'h00;
			counter    <= 13'h0000;
			drive_low  <= 1'b0;
			ack_q      <= 1'b0;
			master_ack <= 1'b0;
			wr_armed   <= 1'b0;
			lock       <= 1'b0;
			pend_lock  <= 1'b0;
			prog_cnt   <= 20'h00000;
			buf_valid  <= 32'h00000000;
		end else if (state == eeprom_pkg::st_prog) begin
			drive_low <= 1'b0;
			if (commit) begin
				state     <= eeprom_pkg::st_idle;
				buf_valid <= 32'h00000000;
				lock      <= lock | pend_lock;
				pend_lock <= 1'b0;
			end else begin
				prog_cnt <= prog_cnt - 20'h00001;
			end
		end else if (start_seen) begin
			// A new start throws away any half-sent write.
			state     <= eeprom_pkg::st_rx;
			phase     <= eeprom_pkg::ph_dev;
			bit_cnt   <= 4'h0;
			drive_low <= 1'b0;
			wr_armed  <= 1'b0;
			buf_valid <= 32'h00000000;
			pend_lock <= 1'b0;
		end else if (stop_seen) begin
			drive_low <= 1'b0;
			wr_armed  <= 1'b0;
			if (wr_armed) begin
				state    <= eeprom_pkg::st_prog;
				prog_cnt <= 20'(PROGRAM_CYCLES - 1);
			end else begin
				state     <= eeprom_pkg::st_idle;
				buf_valid <= 32'h00000000;
				pend_lock <= 1'b0;
			end
		end else begin
			// The tenth slot closes at its falling edge.
			if (scl_fall && state != eeprom_pkg::st_ack) begin
				wr_armed <= 1'b0;
			end
			case (state)
				eeprom_pkg::st_rx: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == `BYTE_DONE) begin
						ack_q     <= next_ack;
						drive_low <= next_ack;
						state     <= eeprom_pkg::st_ack;
						case (phase)
							eeprom_pkg::ph_dev: begin
								rd    <= shreg[0];
								kind  <= (shreg[7:4] == `TYPE_IDPAGE) ?
									eeprom_pkg::k_idpage : eeprom_pkg::k_array;
								phase <= eeprom_pkg::ph_ahi;
							end
							eeprom_pkg::ph_ahi: begin
								addr_hi <= shreg;
								phase   <= eeprom_pkg::ph_alo;
							end
							eeprom_pkg::ph_alo: begin
								phase <= eeprom_pkg::ph_data;
								if (kind == eeprom_pkg::k_array) begin
									counter <= {addr_hi[4:0], shreg};
								end else begin
									counter <= {8'h00, shreg[`OFS_W-1:0]};
									if (addr_hi[2:1] == `REGION_LOCK) begin
										kind <= eeprom_pkg::k_lock;
									end else if (addr_hi[2:1] != `REGION_IDPAGE) begin
										kind <= eeprom_pkg::k_other;
									end
								end
							end
							default: begin
								if (next_ack) begin
									if (kind == eeprom_pkg::k_lock) begin
										pend_lock <= 1'b1;
									end else begin
										buf_valid[counter[`OFS_W-1:0]] <= 1'b1;
										counter <= bump(counter, 1'b0);
									end
								end
							end
						endcase
					end
				end
				eeprom_pkg::st_ack: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (!ack_q && phase == eeprom_pkg::ph_ahi) begin
							state     <= eeprom_pkg::st_idle;
							drive_low <= 1'b0;
						end else if (rd && phase == eeprom_pkg::ph_ahi) begin
							shreg     <= tx_byte;
							drive_low <= ~tx_byte[7];
							counter   <= bump(counter, kind == eeprom_pkg::k_array);
							state     <= eeprom_pkg::st_tx;
						end else begin
							wr_armed  <= ack_q && phase == eeprom_pkg::ph_data;
							drive_low <= 1'b0;
							state     <= eeprom_pkg::st_rx;
						end
					end
				end
				eeprom_pkg::st_tx: begin
					if (scl_fall) begin
						if (bit_cnt == `TX_LAST_BIT) begin
							drive_low  <= 1'b0;
							master_ack <= 1'b0;
							state      <= eeprom_pkg::st_mack;
						end else begin
							shreg     <= {shreg[6:0], 1'b0};
							drive_low <= ~shreg[6];
							bit_cnt   <= bit_cnt + 4'h1;
						end
					end
				end
				eeprom_pkg::st_mack: begin
					if (scl_rise) begin
						master_ack <= ~sda_s;
					end else if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (master_ack) begin
							shreg     <= tx_byte;
							drive_low <= ~tx_byte[7];
							counter   <= bump(counter, kind == eeprom_pkg::k_array);
							state     <= eeprom_pkg::st_tx;
						end else begin
							state <= eeprom_pkg::st_idle;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Staged bytes land in one store at the end of the program time, so an
	// aborted command never disturbs the array.
	always_ff @(posedge I_CLK) begin
		if (state == eeprom_pkg::st_rx && scl_fall && bit_cnt == `BYTE_DONE &&
			phase == eeprom_pkg::ph_data && next_ack) begin
			buf_data[counter[`OFS_W-1:0]] <= shreg;
		end
		if (commit) begin
			for (int i = 0; i < `PAGE_BYTES; i++) begin
				if (buf_valid[i]) begin
					if (kind == eeprom_pkg::k_array) begin
						mem[{counter[`ADDR_W-1:`OFS_W], 5'(i)}] <= buf_data[i];
					end else begin
						id_mem[i] <= buf_data[i];
					end
				end
			end
		end
	end

	// Only a low level is ever driven on the data line.
	assign LINK.dev_sda_o  = 1'b0;
	assign LINK.dev_sda_oe = drive_low;
	assign O_BUSY          = (state == eeprom_pkg::st_prog);
	assign O_ID_LOCKED     = lock;

endmodule : eeprom_target

/* shared/eeprom_defines.svh */
// Purpose: Shared constants for the two-wire EEPROM target and its controller.
// Assumes: 50 MHz system clock on both ends.
// Notes:   Contract list below names each behaviour kept by the two ends.
//
// Contract
// - Byte write: start, 1010, select, write, acks.
// - Protect pin high: NACK data, keep location.
// - Program only on stop right after acked data; target also programs on stop right after acked low address.
// - Programming busy: ignore bus, give no answer.
// - Address counter advances per accepted write byte.
// - Page write: up to 32 bytes before stop.
// - Write increments low five bits, page fixed.
// - Program time: launching stop to acked address.
// - Polling: NACK while busy, ACK when done.
// - Identification page write: 1011, region 00, offset.
// - Locked identification page: NACK its data bytes.
// - Lock command: 1011, region 10, data bit1 set.
// - After lock, later lock data bytes get NACK.
// - Reads 1010/1011 acked regardless of protect pin.
// - Current read uses counter, then increments it.
// - Array reads wrap from last to first byte.
// - One counter shared; page access loads offset.
// - Controller should prefer random read for array.
// - Random read: dummy write address, restart, read.
// - Reads continue while acked; NACK then stop ends.
// - Address byte type, select, direction; mismatch NACK.
// - Thirteen-bit address, high byte first, acked.
// - Start mid-command discards pending write; stop idles.
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

`define TYPE_ARRAY      4'ha
`define TYPE_IDPAGE     4'hb
`define REGION_IDPAGE   2'h0
`define REGION_LOCK     2'h2
`define LOCK_DATA_BIT   1
`define BYTE_DONE       4'h8
`define TX_LAST_BIT     4'h7
`define PAGE_BYTES      32
`define ARRAY_BYTES     8192
`define ADDR_W          13
`define OFS_W           5
`define CLK_MHZ         50
`define PROGRAM_TIME_US 100
`define QUARTER_LAST    3'h3
`define FRAME_LAST      4'h8
`define REG_CMD         8'h00
`define REG_TXDATA      8'h04
`define REG_STATUS      8'h08
`define REG_RXDATA      8'h0c
`define CMD_ACK_BIT     2
`define ST_BUSY_BIT     0
`define ST_ACKED_BIT    1

`endif

/* shared/eeprom_pkg.sv */
// Purpose: Types shared by the EEPROM target and controller.
// Assumes: Constants live in eeprom_defines.svh.
// Notes:   Order of op_t is the command field encoding.
package eeprom_pkg;
	typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_mack,
		st_prog} dev_state_t;
	typedef enum logic [1:0] {ph_dev, ph_ahi, ph_alo, ph_data} phase_t;
	typedef enum logic [1:0] {k_array, k_idpage, k_lock, k_other} kind_t;
	typedef enum logic [1:0] {op_start, op_stop, op_write, op_read} op_t;
endpackage : eeprom_pkg

/* shared/eeprom_link_if.sv */
// Purpose: Two-wire link between controller and EEPROM target.
// Assumes: Data line is open drain; clock is driven by the controller only.
// Notes:   Each end drives low only while its enable is high.
`timescale 1ns/10ps
interface eeprom_link_if;
	logic scl;
	logic ctl_sda_o;
	logic ctl_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda_level;

	// Wired-AND of both drivers with a pull-up when nobody drives.
	assign sda_level = ~((ctl_sda_oe & ~ctl_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport controller (output scl, output ctl_sda_o, output ctl_sda_oe,
		input sda_level);
	modport target (input scl, output dev_sda_o, output dev_sda_oe,
		input sda_level);
endinterface : eeprom_link_if

/* design/eeprom_controller.sv */
// Purpose: Two-wire bus controller ordered by software over APB.
// Assumes: Software sequences start, byte and stop steps itself.
// Notes:   One bit lasts four quarters of four clock cycles each.
`timescale 1ns/10ps
`include "eeprom_defines.svh"
module eeprom_controller (
	input  wire logic         I_CLK,
	input  wire logic         I_RESET,
	input  wire logic         I_PSEL,
	input  wire logic         I_PENABLE,
	input  wire logic         I_PWRITE,
	input  wire logic [7:0]   I_PADDR,
	input  wire logic [31:0]  I_PWDATA,
	output logic [31:0]       O_PRDATA,
	output logic              O_PREADY,
	output logic              O_PSLVERR,
	eeprom_link_if.controller LINK
);

	////////////////////////////////////////////////////////////////////////
	logic [1:0]        sda_sync;
	logic              busy;
	eeprom_pkg::op_t   op;
	logic [8:0]        out_bits;
	logic [8:0]        in_bits;
	logic [7:0]        txdata;
	logic [2:0]        qcnt;
	logic [1:0]        quarter;
	logic [3:0]        slot;
	logic              scl;
	logic              drive_low;
	logic              tick;
	logic              take_cmd;
	logic              mapped;

	// Data line is a pin input: two flip-flops first.
	always_ff @(posedge I_CLK) begin
		sda_sync <= {sda_sync[0], LINK.sda_level};
	end

	assign tick     = busy && qcnt == `QUARTER_LAST;
	assign mapped   = I_PADDR == `REG_CMD || I_PADDR == `REG_TXDATA ||
		I_PADDR == `REG_STATUS || I_PADDR == `REG_RXDATA;
	assign take_cmd = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == `REG_CMD &&
		!busy;

	////////////////////////////////////////////////////////////////////////
	// Register slave: zero wait states, read data captured in setup.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			txdata   <= 8'h00;
			O_PRDATA <= 32'h00000000;
		end else begin
			if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == `REG_TXDATA) begin
				txdata <= I_PWDATA[7:0];
			end
			if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
				case (I_PADDR)
					`REG_TXDATA: O_PRDATA <= {24'h000000, txdata};
					`REG_STATUS: O_PRDATA <= {30'h00000000, ~in_bits[0], busy};
					`REG_RXDATA: O_PRDATA <= {24'h000000, in_bits[8:1]};
					default: O_PRDATA <= 32'h00000000;
				endcase
			end
		end
	end

	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

	////////////////////////////////////////////////////////////////////////
	// Link sequencer. Data changes only while the clock is low, except in
	// start and stop, whose edges fall one quarter inside the high time.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			busy      <= 1'b0;
			op        <= eeprom_pkg::op_start;
			out_bits  <= 9'h1ff;
			in_bits   <= 9'h1ff;
			qcnt      <= 3'h0;
			quarter   <= 2'h0;
			slot      <= 4'h0;
			scl       <= 1'b1;
			drive_low <= 1'b0;
		end else if (take_cmd) begin
			busy    <= 1'b1;
			op      <= eeprom_pkg::op_t'(I_PWDATA[1:0]);
			qcnt    <= 3'h0;
			quarter <= 2'h0;
			slot    <= 4'h0;
			case (eeprom_pkg::op_t'(I_PWDATA[1:0]))
				eeprom_pkg::op_start: drive_low <= 1'b0;
				eeprom_pkg::op_stop: begin
					scl       <= 1'b0;
					drive_low <= 1'b1;
				end
				eeprom_pkg::op_write: begin
					out_bits  <= {txdata, 1'b1};
					drive_low <= ~txdata[7];
				end
				default: begin
					out_bits  <= {8'hff, I_PWDATA[`CMD_ACK_BIT]};
					drive_low <= 1'b0;
				end
			endcase
		end else if (busy) begin
			qcnt <= tick ? 3'h0 : qcnt + 3'h1;
			if (tick) begin
				quarter <= quarter + 2'h1;
				case (quarter)
					2'h0: scl <= 1'b1;
					2'h1: begin
						if (op == eeprom_pkg::op_start) begin
							drive_low <= 1'b1;
						end else if (op == eeprom_pkg::op_stop) begin
							drive_low <= 1'b0;
						end
					end
					2'h2: begin
						if (op != eeprom_pkg::op_stop) begin
							scl <= 1'b0;
						end
						if (op == eeprom_pkg::op_write || op == eeprom_pkg::op_read) begin
							in_bits <= {in_bits[7:0], sda_sync[1]};
						end
					end
					default: begin
						if (op == eeprom_pkg::op_write || op == eeprom_pkg::op_read) begin
							if (slot == `FRAME_LAST) begin
								busy <= 1'b0;
							end else begin
								slot      <= slot + 4'h1;
								out_bits  <= {out_bits[7:0], 1'b1};
								drive_low <= ~out_bits[7];
							end
						end else begin
							busy <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	assign LINK.scl        = scl;
	assign LINK.ctl_sda_o  = 1'b0;
	assign LINK.ctl_sda_oe = drive_low;

endmodule : eeprom_controller

/* bench/serial_eeprom_rw_protocol_sva.sv */
// Purpose: Assertions on the two-wire link and the target status pins.
// Assumes: One clock domain, I_RESET synchronous and active high.
// Notes:   Instantiated beside the link interface; no bind.
`timescale 1ns/10ps
module serial_eeprom_rw_protocol_sva #(
	parameter int unsigned PROGRAM_CYCLES = 400
) (
	input wire logic I_CLK,
	input wire logic I_RESET,
	input wire logic scl,
	input wire logic ctl_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic sda_level,
	input wire logic O_BUSY,
	input wire logic O_ID_LOCKED
);
	logic       prev_scl;
	logic       prev_sda;
	logic [9:0] since_stop;
	logic [15:0] busy_len;

	// Line state one cycle back, used to spot a stop edge.
	always_ff @(posedge I_CLK) begin
		prev_scl <= scl;
		prev_sda <= sda_level;
	end

	// Cycles since the last stop; saturates so it never looks recent again.
	always_ff @(posedge I_CLK) begin
		if (I_RESET)
			since_stop <= 10'h3ff;
		else if (scl && prev_scl && sda_level && !prev_sda)
			since_stop <= 10'h000;
		else if (since_stop != 10'h3ff)
			since_stop <= since_stop + 10'h001;
	end

	// Length of the current busy stretch.
	always_ff @(posedge I_CLK) begin
		if (I_RESET || !O_BUSY)
			busy_len <= 16'h0000;
		else
			busy_len <= busy_len + 16'h0001;
	end

	////////////////////////////////////////
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (I_RESET);

	sequence s_recent_stop;
		since_stop <= 10'h008;
	endsequence
	sequence s_low_setup;
		!scl [*3];
	endsequence

	chk_busy_silent: assert property (O_BUSY |-> !dev_sda_oe)
		else $error("target drives data while programming");
	chk_busy_after_stop: assert property ($rose(O_BUSY) |-> s_recent_stop)
		else $error("programming began without a stop");
	chk_busy_length: assert property (($fell(O_BUSY) && !$past(I_RESET))
		|-> busy_len == PROGRAM_CYCLES) else $error("program time wrong");
	chk_ack_setup: assert property ($rose(dev_sda_oe) |-> s_low_setup)
		else $error("target drive starts too near clock rise");
	chk_release_low: assert property (($fell(dev_sda_oe) && !$past(I_RESET))
		|-> !scl) else $error("target released data while clock high");
	chk_hold_high: assert property ((scl && prev_scl && !$past(I_RESET))
		|-> $stable(dev_sda_oe)) else $error("target data moved in high time");
	chk_only_ctl_frames: assert property ((scl && prev_scl && !$past(I_RESET)
		&& sda_level != prev_sda) |-> $changed(ctl_sda_oe))
		else $error("data changed in high time without controller");
	chk_lock_sticky: assert property (($past(O_ID_LOCKED) && !$past(I_RESET))
		|-> O_ID_LOCKED) else $error("lock bit cleared");
	chk_lock_by_stop: assert property ($rose(O_ID_LOCKED)
		|-> since_stop <= PROGRAM_CYCLES + 16) else $error("lock without command");
endmodule : serial_eeprom_rw_protocol_sva

/* bench/test_serial_eeprom_rw_protocol.sv */
// Purpose: Drives controller over APB against the target, checks outcomes.
// Assumes: Program time shortened to 400 cycles so polling sees busy.
// Notes:   A byte-wide mirror of the array and page holds expectations.
`timescale 1ns/10ps
`include "eeprom_defines.svh"
module test_serial_eeprom_rw_protocol;
	localparam int unsigned PROG = 400;
	logic        I_CLK = 1'b0;
	logic        I_RESET = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic        locked;
	logic [2:0]  sel = 3'h5;
	logic        wp = 1'b0;
	int          seed = 46;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          nacks;
	logic [7:0]  mem [int];
	logic [7:0]  idp [32];
	logic [7:0]  dq [$];
	logic        ackq [$];
	logic [7:0]  rq [$];
	logic [31:0] r;
	logic        e;
	logic        ak;
	logic [12:0] a;

	eeprom_link_if eeprom_link_if_inst ();
	eeprom_controller eeprom_controller_inst (.I_CLK(I_CLK),
		.I_RESET(I_RESET), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.LINK(eeprom_link_if_inst.controller));
	eeprom_target #(.PROGRAM_CYCLES(PROG)) eeprom_target_inst (.I_CLK(I_CLK),
		.I_RESET(I_RESET), .I_SELECT_PIN_2(sel[2]), .I_SELECT_PIN_1(sel[1]),
		.I_SELECT_PIN_0(sel[0]), .I_WRITE_PROTECT(wp), .O_BUSY(busy),
		.O_ID_LOCKED(locked), .LINK(eeprom_link_if_inst.target));
	serial_eeprom_rw_protocol_sva #(.PROGRAM_CYCLES(PROG))
		serial_eeprom_rw_protocol_sva_inst (.I_CLK(I_CLK), .I_RESET(I_RESET),
		.scl(eeprom_link_if_inst.scl),
		.ctl_sda_oe(eeprom_link_if_inst.ctl_sda_oe),
		.dev_sda_oe(eeprom_link_if_inst.dev_sda_oe),
		.sda_level(eeprom_link_if_inst.sda_level),
		.O_BUSY(busy), .O_ID_LOCKED(locked));

	// Clock, and a ceiling on run length so a hang still ends in a verdict.
	always #10 I_CLK = ~I_CLK;
	always @(posedge I_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			num_errors++;
			finish_test();
		end
	end

	////////////////////////////////////////
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		@(posedge I_CLK);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge I_CLK);
		penable <= 1'b1;
		do
			@(posedge I_CLK);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Software must wait for idle before the next command.
	task automatic cmd(input logic [2:0] c);
		apb(1'b1, `REG_CMD, {29'h0, c});
		do
			apb(1'b0, `REG_STATUS, 32'h0);
		while (r[`ST_BUSY_BIT] !== 1'b0);
	endtask : cmd

	task automatic wbyte(input logic [7:0] b);
		apb(1'b1, `REG_TXDATA, {24'h0, b});
		cmd(3'h2);
		apb(1'b0, `REG_STATUS, 32'h0);
		ak = r[`ST_ACKED_BIT];
	endtask : wbyte

	// Top three address bits are sent as ones; the target must ignore them.
	task automatic head(input logic [3:0] t, input logic [12:0] ad);
		cmd(3'h0);
		wbyte({t, sel, 1'b0});
		check(ak, 1'b1);
		wbyte({3'h7, ad[12:8]});
		check(ak, 1'b1);
		wbyte(ad[7:0]);
		check(ak, 1'b1);
	endtask : head

	task automatic poll();
		nacks = 0;
		for (int i = 0; i < 20; i++) begin
			cmd(3'h0);
			wbyte({`TYPE_ARRAY, sel, 1'b0});
			if (ak)
				break;
			nacks++;
		end
		cmd(3'h1);
	endtask : poll

	task automatic put(input logic [3:0] t, input logic [12:0] ad);
		head(t, ad);
		ackq.delete();
		foreach (dq[k]) begin
			wbyte(dq[k]);
			ackq.push_back(ak);
		end
		cmd(3'h1);
		poll();
	endtask : put

	// Reads n bytes at the counter, acking all but the last.
	task automatic rd(input logic [3:0] t, input int n);
		cmd(3'h0);
		wbyte({t, sel, 1'b1});
		check(ak, 1'b1);
		rq.delete();
		for (int i = 0; i < n; i++) begin
			cmd({i == n - 1, 2'h3});
			apb(1'b0, `REG_RXDATA, 32'h0);
			rq.push_back(r[7:0]);
		end
		cmd(3'h1);
	endtask : rd

	function automatic logic [12:0] wrap(input logic [12:0] ad, input int i);
		return {ad[12:5], ad[4:0] + i[4:0]};
	endfunction : wrap

	////////////////////////////////////////
	initial begin
		sel <= 3'($random(seed));
		repeat (8) @(posedge I_CLK);
		I_RESET <= 1'b0;
		repeat (4) @(posedge I_CLK);
		// Byte writes at random places, read back by a dummy-write read.
		for (int k = 0; k < 3; k++) begin
			a = 13'($random(seed));
			dq = '{8'($random(seed))};
			put(`TYPE_ARRAY, a);
			check(ackq[0], 1'b1);
			check(nacks > 0, 1'b1);
			mem[a] = dq[0];
			head(`TYPE_ARRAY, a);
			rd(`TYPE_ARRAY, 1);
			check(rq[0], mem[a]);
		end
		// Protected write is refused, launches nothing, reads still work.
		wp <= 1'b1;
		dq = '{~mem[a]};
		put(`TYPE_ARRAY, a);
		check(ackq[0], 1'b0);
		check(nacks, 0);
		head(`TYPE_ARRAY, a);
		rd(`TYPE_ARRAY, 1);
		check(rq[0], mem[a]);
		wp <= 1'b0;
		// Page write two past the end, starting near it, so offsets wrap.
		a = {8'($random(seed)), 5'h1e};
		dq.delete();
		for (int k = 0; k < 34; k++)
			dq.push_back(8'($random(seed)));
		put(`TYPE_ARRAY, a);
		foreach (dq[k]) begin
			check(ackq[k], 1'b1);
			mem[wrap(a, k)] = dq[k];
		end
		rd(`TYPE_ARRAY, 1);
		check(rq[0], mem[wrap(a, 34)]);
		head(`TYPE_ARRAY, {a[12:5], 5'h00});
		rd(`TYPE_ARRAY, 32);
		foreach (rq[k])
			check(rq[k], mem[{a[12:5], 5'(k)}]);
		// A start after the data byte discards the truncated write.
		a = {a[12:5], 5'h03};
		head(`TYPE_ARRAY, a);
		wbyte(~mem[a]);
		check(ak, 1'b1);
		cmd(3'h0);
		cmd(3'h1);
		poll();
		check(nacks, 0);
		head(`TYPE_ARRAY, a);
		rd(`TYPE_ARRAY, 1);
		check(rq[0], mem[a]);
		// Wrong select bits and wrong type are both ignored.
		cmd(3'h0);
		wbyte({`TYPE_ARRAY, sel ^ 3'h4, 1'b1});
		check(ak, 1'b0);
		cmd(3'h0);
		wbyte({4'h9, sel, 1'b0});
		check(ak, 1'b0);
		cmd(3'h1);
		// Sequential read crosses from the last byte to the first.
		dq = '{8'h5a};
		put(`TYPE_ARRAY, 13'h1fff);
		dq = '{8'ha5};
		put(`TYPE_ARRAY, 13'h0000);
		head(`TYPE_ARRAY, 13'h1fff);
		rd(`TYPE_ARRAY, 2);
		check(rq[0], 8'h5a);
		check(rq[1], 8'ha5);
		// Identification page write from the last offset, wrapping.
		a = {2'($random(seed)), 2'h0, 4'($random(seed)), 5'h1f};
		dq.delete();
		for (int k = 0; k < 33; k++)
			dq.push_back(8'($random(seed)));
		put(`TYPE_IDPAGE, a);
		foreach (dq[k]) begin
			check(ackq[k], 1'b1);
			idp[5'(31 + k)] = dq[k];
		end
		head(`TYPE_IDPAGE, {a[12:5], 5'h00});
		rd(`TYPE_IDPAGE, 32);
		foreach (rq[k])
			check(rq[k], idp[k]);
		rd(`TYPE_IDPAGE, 1);
		check(rq[0], idp[0]);
		// Lock: bit one clear is refused, then locks, then refuses again.
		dq = '{8'hfd};
		put(`TYPE_IDPAGE, 13'h0400);
		check(ackq[0], 1'b0);
		check(locked, 1'b0);
		dq = '{8'h02};
		put(`TYPE_IDPAGE, 13'h0400);
		check(ackq[0], 1'b1);
		check(nacks > 0, 1'b1);
		check(locked, 1'b1);
		put(`TYPE_IDPAGE, 13'h0400);
		check(ackq[0], 1'b0);
		dq = '{~idp[31]};
		put(`TYPE_IDPAGE, a);
		check(ackq[0], 1'b0);
		head(`TYPE_IDPAGE, a);
		rd(`TYPE_IDPAGE, 1);
		check(rq[0], idp[31]);
		// Unmapped register answers with an error and zero data.
		apb(1'b0, 8'h10, 32'h0);
		check(e, 1'b1);
		check(r, 32'h0);
		finish_test();
	end
endmodule : test_serial_eeprom_rw_protocol
